// ===== rtl/rtc_consts.svh
// constants of the real-time clock control block
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define ADDR_SEC1     4'h0
`define ADDR_SEC10    4'h1
`define ADDR_MIN1     4'h2
`define ADDR_MIN10    4'h3
`define ADDR_HOUR1    4'h4
`define ADDR_HOUR10   4'h5
`define ADDR_WDAY     4'h6
`define ADDR_IPSEL    4'h7
`define ADDR_DAY1     4'h8
`define ADDR_DAY10    4'h9
`define ADDR_CTRL     4'hE
`define CTRL_FLAG     3
`define CTRL_FMT      2
`define CTRL_GATE     1
`define CTRL_ADJ      0
`define IPS_LVL       3
`define SYS_CLK_MHZ   20
`define BSY_MAX_NS    122100
`define BSY_CYC       (`BSY_MAX_NS * `SYS_CLK_MHZ / 1000)
`define HALT_US       100
`define HALT_CYC      (`HALT_US * `SYS_CLK_MHZ)
`define PRE_W         15
`define FAST_BIT      4
`define SLOW_BIT      13
`define SEC_LAST      7'h59
`define SEC_HALF      7'h30
`define HR24_LAST     6'h23
`define HR12_LAST     6'h31
`define HR12_MID      6'h12
`define HR24_MID      6'h00
`define DAY_FIRST     6'h01
`define DAY_LAST      6'h31
`define WDAY_LAST     3'h6
`define RST_IPSEL     4'h0
`endif

// ===== rtl/rtc_pkg.sv
// shared types of the real-time clock control block
package rtc_pkg;
   typedef logic [3:0] nibble_t;
   typedef enum logic [2:0] {
      PH_CMD  = 3'b001,
      PH_READ = 3'b010,
      PH_DONE = 3'b100
   } ser_phase_e;
endpackage

// ===== rtl/rtc_bus_if.sv
// register access carrier between serial port and control core
interface rtc_bus_if;
   logic             wr_stb;
   rtc_pkg::nibble_t addr;
   rtc_pkg::nibble_t wdata;
   rtc_pkg::nibble_t rdata;
   logic             sel_low;
   modport port (output wr_stb, addr, wdata, sel_low, input rdata);
   modport core (input wr_stb, addr, wdata, sel_low, output rdata);
endinterface

// ===== rtl/rtc_serial_port.sv
// serial register port sampled on the system clock
`include "rtc_consts.svh"
module rtc_serial_port (
   input  wire logic sys_clk_i, // system clock
   input  wire logic sys_rst_i, // sync reset, high
   input  wire logic sel_i,     // select pin, high = access
   input  wire logic sclk_i,    // shift clock pin
   input  wire logic sio_i,     // data pin in
   output logic      sio_o,     // data pin out
   output logic      sio_oe_o,  // data pin enable
   rtc_bus_if.port   bus        // register access
);
   logic [2:0]          s1_reg;
   logic [2:0]          s2_reg;
   logic                sclk_d_reg;
   logic [3:0]          cnt_reg;
   logic [6:0]          sh_reg;
   rtc_pkg::nibble_t    addr_reg;
   rtc_pkg::nibble_t    out_reg;
   rtc_pkg::nibble_t    wdata_reg;
   rtc_pkg::ser_phase_e ph_reg;
   logic                load_reg;
   logic                wr_reg;
   logic                sel;
   logic                fall;
   logic                rise;
   rtc_pkg::nibble_t    nib;

   assign sel = s2_reg[2];
   assign fall = sclk_d_reg & ~s2_reg[1];
   assign rise = ~sclk_d_reg & s2_reg[1];
   assign nib = {sh_reg[2:0], s2_reg[0]};
   assign bus.wr_stb = wr_reg;
   assign bus.addr = addr_reg;
   assign bus.wdata = wdata_reg;
   assign bus.sel_low = ~sel;

   always_ff @(posedge sys_clk_i) begin
      s1_reg <= {sel_i, sclk_i, sio_i};
      s2_reg <= s1_reg;
      sclk_d_reg <= s2_reg[1];
   end

   always_ff @(posedge sys_clk_i) begin
      load_reg <= 1'b0;
      wr_reg <= 1'b0;
      if (sys_rst_i || !sel) begin
         cnt_reg <= 4'h0;
         ph_reg <= rtc_pkg::PH_CMD;
         sio_oe_o <= 1'b0;
         sio_o <= 1'b0;
         if (sys_rst_i) begin
            sh_reg <= 7'h00;
            addr_reg <= 4'h0;
            out_reg <= 4'h0;
            wdata_reg <= 4'h0;
         end
      end else begin
         case (ph_reg)
            rtc_pkg::PH_CMD: if (fall) begin
               sh_reg <= {sh_reg[5:0], s2_reg[0]};
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == 4'h7) begin
                  cnt_reg <= 4'h0;
                  // control bits: sh[5] read, sh[4] address, sh[3] data
                  if (sh_reg[4] && !sh_reg[3]) addr_reg <= nib;
                  if (sh_reg[5] && sh_reg[4] && !sh_reg[3]) begin
                     ph_reg <= rtc_pkg::PH_READ;
                     load_reg <= 1'b1;
                  end
                  if (sh_reg[3] && !sh_reg[5] && !sh_reg[4]) begin
                     wdata_reg <= nib;
                     wr_reg <= 1'b1;
                  end
               end
            end
            rtc_pkg::PH_READ: begin
               if (load_reg) out_reg <= bus.rdata;
               else if (rise) begin
                  cnt_reg <= cnt_reg + 4'h1;
                  sio_oe_o <= (cnt_reg != 4'h4);
                  sio_o <= out_reg[3];
                  out_reg <= {out_reg[2:0], 1'b0};
                  if (cnt_reg == 4'h4) ph_reg <= rtc_pkg::PH_DONE;
               end
            end
            rtc_pkg::PH_DONE: sio_oe_o <= 1'b0;
            default: ph_reg <= rtc_pkg::PH_CMD;
         endcase
      end
   end
endmodule

// ===== rtl/rtc_osc_base.sv
// crystal time base: prescaler, one-second tick, halt sensing
`include "rtc_consts.svh"
module rtc_osc_base #(
   parameter int PRE_W    = `PRE_W,
   parameter int HALT_CYC = `HALT_CYC
) (
   input  wire logic             sys_clk_i, // system clock
   input  wire logic             sys_rst_i, // sync reset, high
   input  wire logic             xtal_i,    // crystal clock pin
   input  wire logic             sub_clr_i, // clear sub-second count
   output logic                  sec_tick_o, // one-second carry pulse
   output logic [PRE_W-1:0]      presc_o,    // sub-second count
   output logic                  halted_o    // crystal stopped
);
   logic [1:0]  sync_reg;
   logic        xd_reg;
   logic [15:0] idle_reg;
   logic        edge_x;

   if (PRE_W <= `SLOW_BIT || HALT_CYC >= 65536) begin : g_bad
      $error("rtc_osc_base: unsupported parameters");
   end

   assign edge_x = sync_reg[1] & ~xd_reg;

   always_ff @(posedge sys_clk_i) begin
      sync_reg <= {sync_reg[0], xtal_i};
      xd_reg <= sync_reg[1];
   end

   always_ff @(posedge sys_clk_i) begin
      sec_tick_o <= 1'b0;
      if (sys_rst_i) begin
         presc_o <= '0;
         idle_reg <= 16'h0000;
         halted_o <= 1'b0;
      end else begin
         if (edge_x) idle_reg <= 16'h0000;
         else if (!halted_o) idle_reg <= idle_reg + 16'h0001;
         // an edge ends the halt; silence longer than the window starts one
         halted_o <= edge_x ? 1'b0 : (halted_o | (idle_reg >= 16'(HALT_CYC)));
         if (sub_clr_i) presc_o <= '0;
         else if (edge_x) begin
            presc_o <= presc_o + 1'b1;
            sec_tick_o <= &presc_o;
         end
      end
   end
endmodule

// ===== rtl/rtc_control_and_interrupt.sv
// real-time clock control, time counters and interrupt output
// Contract
// - adjust at seconds 00-29: clear sub-seconds, seconds to 00
// - adjust at seconds 30-59: clear sub-seconds, seconds to 00, minutes plus one
// - adjust waits while carry gate is 0
// - busy flag reads 1 at most 122.1 us after an adjust write
// - select pin low forces carry gate to 1
// - one-second carry held while gate is 0, applied when gate returns
// - with select low, crystal halt sets the halt flag, which stays set
// - with select high, a crystal halt does not set the halt flag
// - a control register write during oscillation clears the halt flag
// - hours count 00-23, or 12,01-11 then 32,21-31 in 12-hour form
// - interrupt flag is 1 whenever the interrupt output is low
// - selector top bit: 0 pulse mode, 1 level mode
// - flag writable only in level mode; 1 pulls output low, 0 releases
// - pulse codes: off, held low, 0.977 ms 50% square, 0.5 s square
// - level codes 0-3: each second, ten seconds, minute, ten minutes
// - level codes 4-7: each hour, day, week, month at midnight
// - the four-bit selector at 7h reads back what was written
// - control D1 gate on write, halt on read; D0 adjust / busy
// - carry gate 0 blocks the one-second carry, 1 allows it
`include "rtc_consts.svh"
module rtc_control_and_interrupt #(
   parameter int HALT_CYC = `HALT_CYC
) (
   input  wire logic sys_clk_i,      // system clock, 20 MHz
   input  wire logic sys_rst_i,      // sync reset, high
   input  wire logic sel_i,          // select pin from host
   input  wire logic sclk_i,         // serial shift clock pin
   input  wire logic sio_i,          // serial data pin in
   output logic      sio_o,          // serial data pin out
   output logic      sio_oe_o,       // serial data pin enable
   input  wire logic xtal_i,         // crystal time base pin
   output logic      irq_out_n_o,    // interrupt pin level when driven
   output logic      irq_out_n_oe_o  // interrupt pin pull-down enable
);
   ////////////////////////////////////////////////////////////////////
   rtc_bus_if bus ();

   logic              sec_tick;
   logic [`PRE_W-1:0] presc;
   logic              halted;
   logic              do_adj;

   rtc_serial_port u_port (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .sel_i     (sel_i),
      .sclk_i    (sclk_i),
      .sio_i     (sio_i),
      .sio_o     (sio_o),
      .sio_oe_o  (sio_oe_o),
      .bus       (bus)
   );

   rtc_osc_base #(
      .PRE_W    (`PRE_W),
      .HALT_CYC (HALT_CYC)
   ) u_osc (
      .sys_clk_i  (sys_clk_i),
      .sys_rst_i  (sys_rst_i),
      .xtal_i     (xtal_i),
      .sub_clr_i  (do_adj),
      .sec_tick_o (sec_tick),
      .presc_o    (presc),
      .halted_o   (halted)
   );

   ////////////////////////////////////////////////////////////////////
   // bcd step with wrap to a floor value
   function automatic logic [6:0] bcd_step(input logic [6:0] v,
                                           input logic [6:0] last,
                                           input logic [6:0] first);
      logic [6:0] r;
      r = {v[6:4], v[3:0] + 4'h1};
      if (v == last) r = first;
      else if (v[3:0] == 4'h9) r = {v[6:4] + 3'h1, 4'h0};
      return r;
   endfunction

   function automatic logic [5:0] hour_step(input logic [5:0] h,
                                            input logic h24);
      logic [5:0] r;
      r = 6'(bcd_step({1'b0, h}, {1'b0, `HR24_LAST}, 7'h00));
      if (!h24) begin
         // eleven o'clock rolls to twelve and flips the afternoon bit
         if (h[4:0] == 5'h11) r = {~h[5], 5'(`HR12_MID)};
         else if (h[4:0] == 5'h12) r = {h[5], 5'h01};
         else r = {h[5], 5'(bcd_step({2'b00, h[4:0]}, 7'h7F, 7'h00))};
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   logic [3:0]  ipsel_reg;
   logic        fmt24_reg;
   logic        gate_reg;
   logic        adj_pend_reg;
   logic        carry_pend_reg;
   logic [11:0] busy_reg;
   logic        halt_reg;
   logic        irq_flag_reg;
   logic        step_reg;
   logic [6:0]  sec_reg;
   logic [6:0]  min_reg;
   logic [5:0]  hour_reg;
   logic [2:0]  wday_reg;
   logic [5:0]  day_reg;

   logic        wr_ctrl;
   logic        wr_ipsel;
   logic        adj_req;
   logic        do_carry;
   logic        carry_min;
   logic        carry_hour;
   logic        carry_day;
   logic        busy;
   logic        level_mode;
   logic        midnight;
   logic        hour_top;
   logic        match;
   logic        pulse_low;
   logic        irq_next;
   logic [6:0]  sec_next;
   logic [6:0]  min_next;
   logic [5:0]  hour_next;
   logic [2:0]  wday_next;
   logic [5:0]  day_next;

   localparam logic [11:0] BSY_CYC = 12'(`BSY_CYC);

   ////////////////////////////////////////////////////////////////////
   assign wr_ctrl  = bus.wr_stb && (bus.addr == `ADDR_CTRL);
   assign wr_ipsel = bus.wr_stb && (bus.addr == `ADDR_IPSEL);
   assign adj_req  = wr_ctrl && bus.wdata[`CTRL_ADJ];
   assign busy     = (busy_reg != 12'h000);
   assign do_adj   = adj_pend_reg && gate_reg;
   // an adjust swallows a carry of the same cycle: the second restarts
   assign do_carry = gate_reg && !do_adj && (sec_tick || carry_pend_reg);
   assign carry_min  = do_adj ? (sec_reg >= `SEC_HALF)
                              : (do_carry && (sec_reg == `SEC_LAST));
   assign hour_top   = fmt24_reg ? (hour_reg == `HR24_LAST) : (hour_reg == `HR12_LAST);
   assign carry_hour = carry_min && (min_reg == `SEC_LAST);
   assign carry_day  = carry_hour && hour_top;
   assign level_mode = ipsel_reg[`IPS_LVL];
   assign midnight   = fmt24_reg ? (hour_reg == `HR24_MID) : (hour_reg == `HR12_MID);

   ////////////////////////////////////////////////////////////////////
   // counter next values: counting first, a host write to a digit overrides
   always_comb begin
      sec_next  = sec_reg;
      min_next  = min_reg;
      hour_next = hour_reg;
      wday_next = wday_reg;
      day_next  = day_reg;
      if (do_adj) sec_next = 7'h00;
      else if (do_carry) sec_next = bcd_step(sec_reg, `SEC_LAST, 7'h00);
      if (carry_min) min_next = bcd_step(min_reg, `SEC_LAST, 7'h00);
      if (carry_hour) hour_next = hour_step(hour_reg, fmt24_reg);
      if (carry_day) begin
         wday_next = (wday_reg == `WDAY_LAST) ? 3'h0 : wday_reg + 3'h1;
         day_next  = 6'(bcd_step({1'b0, day_reg}, {1'b0, `DAY_LAST}, {1'b0, `DAY_FIRST}));
      end
      if (bus.wr_stb) begin
         case (bus.addr)
            `ADDR_SEC1:   sec_next[3:0]  = bus.wdata;
            `ADDR_SEC10:  sec_next[6:4]  = bus.wdata[2:0];
            `ADDR_MIN1:   min_next[3:0]  = bus.wdata;
            `ADDR_MIN10:  min_next[6:4]  = bus.wdata[2:0];
            `ADDR_HOUR1:  hour_next[3:0] = bus.wdata;
            `ADDR_HOUR10: hour_next[5:4] = bus.wdata[1:0];
            `ADDR_WDAY:   wday_next      = bus.wdata[2:0];
            default:      sec_next       = sec_next;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // level-mode event on the freshly stepped time
   always_comb begin
      case (ipsel_reg[2:0])
         3'b000:  match = 1'b1;
         3'b001:  match = (sec_reg[3:0] == 4'h0);
         3'b010:  match = (sec_reg == 7'h00);
         3'b011:  match = (sec_reg == 7'h00) && (min_reg[3:0] == 4'h0);
         3'b100:  match = (sec_reg == 7'h00) && (min_reg == 7'h00);
         3'b101:  match = (sec_reg == 7'h00) && (min_reg == 7'h00) && midnight;
         3'b110:  match = (sec_reg == 7'h00) && (min_reg == 7'h00) && midnight
                          && (wday_reg == 3'h0);
         default: match = (sec_reg == 7'h00) && (min_reg == 7'h00) && midnight
                          && (day_reg == `DAY_FIRST);
      endcase
   end

   always_comb begin
      case (ipsel_reg[1:0])
         2'b00:   pulse_low = 1'b0;
         2'b01:   pulse_low = 1'b1;
         2'b10:   pulse_low = presc[`FAST_BIT];
         default: pulse_low = presc[`SLOW_BIT];
      endcase
   end

   // event beats a host clear in the same cycle
   always_comb begin
      if (level_mode) begin
         irq_next = wr_ctrl ? bus.wdata[`CTRL_FLAG] : irq_flag_reg;
         if (step_reg && match) irq_next = 1'b1;
      end else begin
         irq_next = pulse_low;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      case (bus.addr)
         `ADDR_SEC1:   bus.rdata = sec_reg[3:0];
         `ADDR_SEC10:  bus.rdata = {1'b0, sec_reg[6:4]};
         `ADDR_MIN1:   bus.rdata = min_reg[3:0];
         `ADDR_MIN10:  bus.rdata = {1'b0, min_reg[6:4]};
         `ADDR_HOUR1:  bus.rdata = hour_reg[3:0];
         `ADDR_HOUR10: bus.rdata = {2'b00, hour_reg[5:4]};
         `ADDR_WDAY:   bus.rdata = {1'b0, wday_reg};
         `ADDR_IPSEL:  bus.rdata = ipsel_reg;
         `ADDR_DAY1:   bus.rdata = day_reg[3:0];
         `ADDR_DAY10:  bus.rdata = {2'b00, day_reg[5:4]};
         `ADDR_CTRL:   bus.rdata = {irq_flag_reg, fmt24_reg, halt_reg, busy};
         default:      bus.rdata = 4'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sec_reg  <= 7'h00;
         min_reg  <= 7'h00;
         hour_reg <= 6'h00;
         wday_reg <= 3'h0;
         day_reg  <= `DAY_FIRST;
         step_reg <= 1'b0;
      end else begin
         sec_reg  <= sec_next;
         min_reg  <= min_next;
         hour_reg <= hour_next;
         wday_reg <= wday_next;
         day_reg  <= day_next;
         step_reg <= do_adj || do_carry;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ipsel_reg <= `RST_IPSEL;
         fmt24_reg <= 1'b1;
      end else begin
         if (wr_ipsel) ipsel_reg <= bus.wdata;
         if (wr_ctrl) fmt24_reg <= bus.wdata[`CTRL_FMT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         gate_reg <= 1'b1;
      end else if (bus.sel_low) begin
         gate_reg <= 1'b1;
      end else if (wr_ctrl) begin
         gate_reg <= bus.wdata[`CTRL_GATE];
      end
   end

   // a pending carry is kept for as long as the gate stays closed
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         adj_pend_reg   <= 1'b0;
         carry_pend_reg <= 1'b0;
      end else begin
         adj_pend_reg   <= adj_req || (adj_pend_reg && !do_adj);
         carry_pend_reg <= !gate_reg && (sec_tick || carry_pend_reg);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) busy_reg <= 12'h000;
      else if (adj_req || do_carry || do_adj) busy_reg <= BSY_CYC;
      else if (busy) busy_reg <= busy_reg - 12'h001;
   end

   // halt sensing only while the select pin is low; a new halt beats the clear
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) halt_reg <= 1'b0;
      else if (bus.sel_low && halted) halt_reg <= 1'b1;
      else if (wr_ctrl && !halted) halt_reg <= 1'b0;
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_flag_reg   <= 1'b0;
         irq_out_n_oe_o <= 1'b0;
      end else begin
         irq_flag_reg   <= irq_next;
         irq_out_n_oe_o <= irq_next;
      end
   end

   // open drain: the pin is only ever pulled low
   assign irq_out_n_o = 1'b0;
endmodule

// ===== verif/serial_host_model.sv
// host processor model that drives the serial register port
module serial_host_model (
   input  wire logic sys_clk_i, // system clock
   output logic      sel_o,     // select pin
   output logic      sclk_o,    // shift clock pin
   output logic      sio_o,     // data line into device
   input  wire logic sio_i,     // device data out
   input  wire logic sio_oe_i   // device drives data line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv = 1'b0;
   logic bit_v = 1'b0;
   logic flip = 1'b0;
   // a released line keeps changing so a stale bit never reads as valid
   assign sio_o = sio_oe_i ? sio_i : (drv ? bit_v : flip);
   always @(posedge sys_clk_i) flip <= ~flip;
   initial begin
      sel_o = 1'b0;
      sclk_o = 1'b0;
   end
   //////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic sel_up();
      sel_o = 1'b1;
      wt(4);
   endtask
   task automatic sel_down();
      drv = 1'b0;
      sel_o = 1'b0;
      wt(8);
   endtask
   // shift clock idles low between frames; 8 cycles make 400 ns
   task automatic put8(input logic [7:0] b);
      drv = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         sclk_o = 1'b1;
         bit_v = b[i];
         wt(4);
         sclk_o = 1'b0;
         wt(4);
      end
   endtask
   task automatic get4(output logic [3:0] d);
      drv = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         sclk_o = 1'b1;
         wt(4);
         sclk_o = 1'b0;
         wt(4);
         d[i] = sio_i;
      end
   endtask
endmodule

// ===== verif/rtc_control_and_interrupt_sva.sv
// pin-level checks of the real-time clock control block
module rtc_control_and_interrupt_sva #(
   parameter int HALT_CYC = 2000
) (
   input wire logic sys_clk_i,     // system clock
   input wire logic sys_rst_i,     // sync reset
   input wire logic sel_i,         // select pin
   input wire logic sclk_i,        // shift clock
   input wire logic sio_oe_o,      // data enable
   input wire logic irq_out_n_o,   // irq level
   input wire logic irq_out_n_oe_o // irq enable
);
   timeunit 1ns;
   timeprecision 1ns;
   logic seen_sel_reg;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // selector resets to off, so no interrupt before a first access
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         seen_sel_reg <= 1'b0;
      end else if (sel_i) begin
         seen_sel_reg <= 1'b1;
      end
   end
   //////////////////////////////////////////////////////////////
   property p_rst_quiet;
      $fell(sys_rst_i) |-> !irq_out_n_oe_o && !sio_oe_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("output active at reset release");
   property p_quiet_boot;
      !seen_sel_reg |-> !irq_out_n_oe_o;
   endproperty
   a_quiet_boot: assert property (p_quiet_boot)
      else $error("interrupt before any access");
   property p_irq_pin;
      irq_out_n_oe_o |-> !irq_out_n_o;
   endproperty
   a_irq_pin: assert property (p_irq_pin)
      else $error("interrupt pin not pulled low");
   property p_sio_idle;
      !sel_i [*5] |-> !sio_oe_o;
   endproperty
   a_sio_idle: assert property (p_sio_idle)
      else $error("data pin driven while deselected");
   property p_oe_in_frame;
      $rose(sio_oe_o) |-> $past(sel_i);
   endproperty
   a_oe_in_frame: assert property (p_oe_in_frame)
      else $error("data pin driven outside a frame");
   property p_oe_bounded;
      $rose(sio_oe_o) |-> ##[1:48] !sio_oe_o;
   endproperty
   a_oe_bounded: assert property (p_oe_bounded)
      else $error("data pin driven too long");
   property p_oe_holds;
      $rose(sio_oe_o) |-> (sio_oe_o || !sel_i) [*8];
   endproperty
   a_oe_holds: assert property (p_oe_holds)
      else $error("data pin released inside a read");
   property p_oe_after_rise;
      $rose(sio_oe_o) |-> $past(sclk_i, 2) || $past(sclk_i, 3);
   endproperty
   a_oe_after_rise: assert property (p_oe_after_rise)
      else $error("data pin driven without shift clock rise");
endmodule
bind rtc_control_and_interrupt rtc_control_and_interrupt_sva #(.HALT_CYC(HALT_CYC)) chk_i (
   .sys_clk_i      (sys_clk_i),
   .sys_rst_i      (sys_rst_i),
   .sel_i          (sel_i),
   .sclk_i         (sclk_i),
   .sio_oe_o       (sio_oe_o),
   .irq_out_n_o    (irq_out_n_o),
   .irq_out_n_oe_o (irq_out_n_oe_o)
);

// ===== verif/rtc_control_and_interrupt_bench.sv
// self-checking bench of the real-time clock control block
`include "rtc_consts.svh"
module rtc_control_and_interrupt_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALT = 20;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic sel, sclk, sio_in, sio_out, sio_oe, irq_n, irq_oe;
   logic xtal = 1'b0;
   logic xtal_run = 1'b1;
   logic [31:0] lfsr = 32'hE9086CA1;
   logic [3:0] got, v, min_exp;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   int t, hi;
   rtc_control_and_interrupt #(.HALT_CYC(HALT)) DUT (
      .sys_clk_i      (sys_clk_i),
      .sys_rst_i      (sys_rst_i),
      .sel_i          (sel),
      .sclk_i         (sclk),
      .sio_i          (sio_in),
      .sio_o          (sio_out),
      .sio_oe_o       (sio_oe),
      .xtal_i         (xtal),
      .irq_out_n_o    (irq_n),
      .irq_out_n_oe_o (irq_oe)
   );
   serial_host_model host (
      .sys_clk_i (sys_clk_i),
      .sel_o     (sel),
      .sclk_o    (sclk),
      .sio_o     (sio_in),
      .sio_i     (sio_out),
      .sio_oe_i  (sio_oe)
   );
   always #25 sys_clk_i = ~sys_clk_i;
   // crystal sped up so one second fits in the run
   always @(negedge sys_clk_i) if (xtal_run) xtal <= ~xtal;
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         n_fail++;
         stop_test();
      end
   end
   //////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [3:0] adj_min(input int s, input logic [3:0] m);
      return (s >= 30) ? m + 4'h1 : m;
   endfunction
   task automatic chk(input logic [3:0] g, input logic [3:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_pin(input logic e);
      chk({3'h0, irq_oe}, {3'h0, e});
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      host.sel_up();
      host.put8({4'h2, a});
      host.put8({4'h1, d});
      host.sel_down();
   endtask
   task automatic rdc(input logic [3:0] a, input logic [3:0] e);
      host.sel_up();
      host.put8({4'h6, a});
      host.get4(got);
      host.sel_down();
      chk(got, e);
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////
   initial begin
      host.wt(10);
      sys_rst_i = 1'b0;
      host.wt(4);
      xtal_run = 1'b0;
      host.wt(3 * HALT);
      xtal_run = 1'b1;
      host.wt(10);
      rdc(`ADDR_CTRL, 4'h6);
      wr(`ADDR_CTRL, 4'h6);
      rdc(`ADDR_CTRL, 4'h4);
      host.sel_up();
      xtal_run = 1'b0;
      host.wt(3 * HALT);
      xtal_run = 1'b1;
      host.put8({4'h6, `ADDR_CTRL});
      host.get4(got);
      host.sel_down();
      chk(got, 4'h4);
      min_exp = 4'h0;
      for (int i = 0; i < 3; i++) begin
         lfsr = nxt(lfsr);
         t = (i == 0) ? 29 : (i == 1) ? 30 : int'(lfsr % 60);
         wr(`ADDR_SEC1, 4'(t % 10));
         wr(`ADDR_SEC10, 4'(t / 10));
         host.sel_up();
         host.put8({4'h2, `ADDR_CTRL});
         host.put8({4'h1, 4'h5});
         host.put8({4'h6, `ADDR_SEC1});
         host.get4(got);
         host.sel_down();
         chk(got, 4'(t % 10));
         rdc(`ADDR_CTRL, 4'h5);
         rdc(`ADDR_SEC1, 4'h0);
         rdc(`ADDR_SEC10, 4'h0);
         min_exp = adj_min(t, min_exp);
         rdc(`ADDR_MIN1, min_exp);
         host.wt(2500);
         rdc(`ADDR_CTRL, 4'h4);
      end
      lfsr = nxt(lfsr);
      for (int k = 0; k < 16; k++) begin
         v = 4'(k) ^ lfsr[3:0];
         wr(`ADDR_IPSEL, v);
         rdc(`ADDR_IPSEL, v);
         if (!v[3] && !v[1]) chk_pin(v[0]);
         if (!v[3] && v[1:0] == 2'h2) begin
            hi = 0;
            repeat (160) begin
               @(negedge sys_clk_i);
               hi += (irq_oe === 1'b1);
            end
            chk({3'h0, hi > 60 && hi < 100}, 4'h1);
         end
         // a flag left from a pulse code would hold the pin in level mode
         if (v[3]) wr(`ADDR_CTRL, 4'h6);
      end
      wr(`ADDR_IPSEL, 4'hF);
      wr(`ADDR_CTRL, 4'hE);
      chk_pin(1'b1);
      rdc(`ADDR_CTRL, 4'hC);
      wr(`ADDR_CTRL, 4'h6);
      chk_pin(1'b0);
      wr(`ADDR_IPSEL, 4'h0);
      wr(`ADDR_CTRL, 4'hE);
      rdc(`ADDR_CTRL, 4'h4);
      wr(`ADDR_IPSEL, 4'h8);
      hi = 0;
      while (irq_oe !== 1'b1 && hi < 70000) begin
         @(negedge sys_clk_i);
         hi++;
      end
      chk_pin(1'b1);
      host.wt(200);
      chk_pin(1'b1);
      wr(`ADDR_CTRL, 4'h6);
      chk_pin(1'b0);
      stop_test();
   end
endmodule
